// ===== hdl/frpp_consts.vh
// Purpose: Constants for the flash row program and protect sequencer
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes:   Timing counts derive from times in ns and the 8 ns clock
`ifndef FRPP_CONSTS_VH
`define FRPP_CONSTS_VH

// Register byte offsets
`define FRPP_OFS_CTRL        4'h0
`define FRPP_OFS_PROTECT     4'h4
`define FRPP_OFS_STATUS      4'h8
`define FRPP_OFS_FADDR       4'hC

// Control register fields
`define FRPP_CTRL_PGM_BIT    0
`define FRPP_CTRL_ERASE_BIT  1
`define FRPP_CTRL_MASS_BIT   2
`define FRPP_CTRL_HIGH_VOLTAGE_ENABLE_BIT   3

// Flash address register fields: data in 7:0, address in 23:8, go in 31
`define FRPP_FADDR_GO_BIT    31

// Status register fields
`define FRPP_ST_PROT_READ    0
`define FRPP_ST_LATCHED      1
`define FRPP_ST_REFUSED      2
`define FRPP_ST_NVS_DONE     3
`define FRPP_ST_BUSY         4

// Protect byte reset value (erased) and fixed protect positions
`define FRPP_PROTECT_ERASED  8'hFF
`define FRPP_PROTECT_ALL     8'h00
`define FRPP_PROTECT_ADDR    16'hFFBE
`define FRPP_ALWAYS_LO       16'hBE00
`define FRPP_ROW_BYTES       32
`define FRPP_ROW_MASK        16'hFFE0

// Setup wait in ns and derived cycles (least time, rounded up)
`define FRPP_CLK_NS          8
`define FRPP_SETUP_NS        10000
`define FRPP_SETUP_CYC       ((`FRPP_SETUP_NS + `FRPP_CLK_NS - 1) / `FRPP_CLK_NS)

`endif

// ===== hdl/frpp_protect_map.v
// Purpose: Decide whether a flash address lies in the protected range
// Assumes: Protect byte already valid; addresses are 16-bit
// Notes:   Pure combinational compare
`timescale 1ns/1ns
`default_nettype none
`include "frpp_consts.vh"

module frpp_protect_map (
  input  wire [7:0]  i_protect_start_bits,  // Protect byte
  input  wire [15:0] i_addr,                // Target address
  output wire        o_protected,           // Address is protected
  output wire        o_any_protect          // Some block is protected
);

  // Start address: bits 15:14 one, 13:6 from byte, 5:0 zero
  wire [15:0] start_addr = {2'b11, i_protect_start_bits, 6'h00};

  // All ones leaves everything open, zero locks everything
  assign o_any_protect = (i_protect_start_bits != `FRPP_PROTECT_ERASED);
  assign o_protected   = o_any_protect &&
                         ((i_protect_start_bits == `FRPP_PROTECT_ALL) ||
                          (i_addr >= `FRPP_ALWAYS_LO && i_addr < 16'hC000) ||
                          (i_addr >= start_addr) ||
                          (i_addr == `FRPP_PROTECT_ADDR));

endmodule // frpp_protect_map

`default_nettype wire

// ===== hdl/frpp_wait_timer.v
// Purpose: Count a fixed wait after a start pulse
// Assumes: One clock domain
// Notes:   Restart on every start pulse
`timescale 1ns/1ns
`default_nettype none

module frpp_wait_timer #(
  parameter integer COUNT = 1250  // Cycles to wait
) (
  input  wire i_sys_clk,  // Clock
  input  wire i_reset,    // Synchronous reset
  input  wire i_start,    // Restart pulse
  input  wire i_clear,    // Abandon wait
  output reg  o_done      // Wait elapsed, level
);

  reg [31:0] count;  // Remaining cycles
  reg        run;    // Counting

  // Load on start, count down, flag when one is left
  always @(posedge i_sys_clk) begin
    if (i_reset || i_clear) begin
      count  <= 32'h00000000;
      run    <= 1'b0;
      o_done <= 1'b0;
    end else if (i_start) begin
      count  <= COUNT;
      run    <= 1'b1;
      o_done <= 1'b0;
    end else if (run) begin
      if (count <= 32'h00000001) begin
        run    <= 1'b0;
        o_done <= 1'b1;
      end else begin
        count <= count - 32'h00000001;
      end
    end
  end

endmodule // frpp_wait_timer

`default_nettype wire

// ===== hdl/frpp_sequencer.v
// Purpose: Flash row program sequencer with block write protection
// Assumes: Avalon-MM slave, one clock, flash array and pump are outside
// Notes:   Software paces the sequence; the block gates high voltage
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "frpp_consts.vh"

module frpp_sequencer #(
  parameter integer SETUP_CYC = `FRPP_SETUP_CYC  // Setup wait in cycles
) (
  input  wire        i_sys_clk,           // Clock, 125 MHz
  input  wire        i_reset,             // Synchronous reset, active high
  input  wire [3:0]  i_avs_address,       // Byte address
  input  wire        i_avs_read,          // Read request
  input  wire        i_avs_write,         // Write request
  input  wire [31:0] i_avs_writedata,     // Write data
  output reg  [31:0] o_avs_readdata,      // Read data
  output wire        o_avs_waitrequest,   // Stall
  input  wire        i_test_high_voltage, // Test voltage on interrupt pin
  input  wire [7:0]  i_protect_load,      // Protect byte from array at start
  output reg         o_program_select,    // Array program mode
  output reg         o_erase_select,      // Array erase mode
  output reg         o_mass_select,       // Array mass erase mode
  output reg         o_high_voltage_enable, // Charge pump on
  output reg         o_latch_strobe,      // Latch address and data, pulse
  output reg  [15:0] o_latch_addr,        // Latched address
  output reg  [7:0]  o_latch_data         // Latched data
);

  // Control and sequence state
  reg [7:0]  protect_start_bits;  // Protect byte copy
  reg        prot_read;           // Protect byte read since select
  reg        latched;             // Latching write since select
  reg        refused;             // Last voltage request or select write refused, sticky
  reg [15:0] target_addr;         // First latched address
  reg        ack;                 // Answer phase of a bus access
  reg        setup_start;         // Starts the setup wait
  reg        protect_loaded;      // Protect byte sampled after reset
  wire       setup_done;          // Setup wait elapsed
  wire       tgt_protected;       // Target row protected
  wire       any_protect;         // Some block protected

  wire wr      = i_avs_write && !ack;
  wire rd      = i_avs_read && !ack;
  wire sel_any = o_program_select || o_erase_select;

  // One wait state per access, then release
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;

  frpp_protect_map u_map (
    .i_protect_start_bits (protect_start_bits),
    .i_addr               (target_addr),
    .o_protected          (tgt_protected),
    .o_any_protect        (any_protect)
  );

  frpp_wait_timer #(
    .COUNT (SETUP_CYC)
  ) u_setup (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_start   (setup_start),
    .i_clear   (!sel_any),
    .o_done    (setup_done)
  );

  // Bus acknowledge toggles one cycle after a request
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_avs_read || i_avs_write) && !ack;
    end
  end

  // Read path: registered data at the answering edge
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h00000000;
    end else if (rd) begin
      case (i_avs_address)
        `FRPP_OFS_CTRL:    o_avs_readdata <= {28'h0000000, o_high_voltage_enable,
                                              o_mass_select, o_erase_select,
                                              o_program_select};
        `FRPP_OFS_PROTECT: o_avs_readdata <= {24'h000000, protect_start_bits};
        `FRPP_OFS_STATUS:  o_avs_readdata <= {27'h0000000, sel_any, setup_done,
                                              refused, latched, prot_read};
        `FRPP_OFS_FADDR:   o_avs_readdata <= {8'h00, target_addr, o_latch_data};
        default:           o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Main sequencer: selects, latch, voltage gate, protect update
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_program_select      <= 1'b0;
      o_erase_select        <= 1'b0;
      o_mass_select         <= 1'b0;
      o_high_voltage_enable <= 1'b0;
      o_latch_strobe        <= 1'b0;
      o_latch_addr          <= 16'h0000;
      o_latch_data          <= 8'h00;
      protect_start_bits    <= `FRPP_PROTECT_ERASED;
      protect_loaded        <= 1'b0;
      prot_read             <= 1'b0;
      latched               <= 1'b0;
      refused               <= 1'b0;
      target_addr           <= 16'h0000;
      setup_start           <= 1'b0;
    end else begin
      o_latch_strobe <= 1'b0;
      setup_start    <= 1'b0;
      // Catch the stored protect byte once after reset release
      if (!protect_loaded) begin
        protect_start_bits <= i_protect_load;
        protect_loaded     <= 1'b1;
      end
      // Reading the protect byte counts only inside a sequence
      if (rd && i_avs_address == `FRPP_OFS_PROTECT && sel_any) begin
        prot_read <= 1'b1;
      end
      if (wr && i_avs_address == `FRPP_OFS_CTRL) begin
        // Select bits: neither may rise while the other is one
        if (i_avs_writedata[`FRPP_CTRL_PGM_BIT] && i_avs_writedata[`FRPP_CTRL_ERASE_BIT]) begin
          refused <= 1'b1;
        end else begin
          if (!o_erase_select || !i_avs_writedata[`FRPP_CTRL_ERASE_BIT]) begin
            o_program_select <= i_avs_writedata[`FRPP_CTRL_PGM_BIT] && !o_erase_select;
          end
          if (!o_program_select || !i_avs_writedata[`FRPP_CTRL_PGM_BIT]) begin
            o_erase_select <= i_avs_writedata[`FRPP_CTRL_ERASE_BIT] && !o_program_select;
          end
          o_mass_select <= i_avs_writedata[`FRPP_CTRL_MASS_BIT];
        end
        // A select bit leaving zero restarts the tracked steps
        if (!sel_any && (i_avs_writedata[`FRPP_CTRL_PGM_BIT] ||
                         i_avs_writedata[`FRPP_CTRL_ERASE_BIT])) begin
          prot_read <= 1'b0;
          latched   <= 1'b0;
        end
        // Voltage request is gated by steps, timer and protection
        if (i_avs_writedata[`FRPP_CTRL_HIGH_VOLTAGE_ENABLE_BIT] && !o_high_voltage_enable) begin
          if (sel_any && prot_read && latched && setup_done &&
              !tgt_protected &&
              !(o_mass_select && any_protect) &&
              !(target_addr == `FRPP_PROTECT_ADDR && !i_test_high_voltage)) begin
            o_high_voltage_enable <= 1'b1;
            refused               <= 1'b0;
          end else begin
            refused <= 1'b1;
          end
        end else if (!i_avs_writedata[`FRPP_CTRL_HIGH_VOLTAGE_ENABLE_BIT]) begin
          o_high_voltage_enable <= 1'b0;
        end
      end
      // Flash write: first latches the row, later ones program bytes
      if (wr && i_avs_address == `FRPP_OFS_FADDR &&
          i_avs_writedata[`FRPP_FADDR_GO_BIT] && sel_any) begin
        if (!latched) begin
          if (prot_read) begin
            latched     <= 1'b1;
            target_addr <= i_avs_writedata[23:8];
            setup_start <= 1'b1;
          end
        end else if (o_program_select && o_high_voltage_enable &&
                     ((i_avs_writedata[23:8] & `FRPP_ROW_MASK) ==
                      (target_addr & `FRPP_ROW_MASK))) begin
          o_latch_strobe <= 1'b1;
          o_latch_addr   <= i_avs_writedata[23:8];
          o_latch_data   <= i_avs_writedata[7:0];
          // Programming only clears bits; protect copy follows the array
          if (i_avs_writedata[23:8] == `FRPP_PROTECT_ADDR) begin
            protect_start_bits <= protect_start_bits & i_avs_writedata[7:0];
          end
        end
      end
      // Page erase of the protect byte page restores erased value
      if (o_erase_select && o_high_voltage_enable && !o_mass_select &&
          target_addr[15:6] == `FRPP_PROTECT_ADDR >> 6 &&
          wr && i_avs_address == `FRPP_OFS_CTRL &&
          !i_avs_writedata[`FRPP_CTRL_ERASE_BIT]) begin
        protect_start_bits <= `FRPP_PROTECT_ERASED;
      end
    end
  end

endmodule // frpp_sequencer

`default_nettype wire

// ===== tb/frpp_sequencer_properties.sv
// Purpose: Port-level timing checks for the row program sequencer
// Assumes: Sees only the top module ports, one clock domain
// Notes:   Bound to every sequencer instance at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module frpp_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_program_select,
  input wire logic        o_erase_select,
  input wire logic        o_high_voltage_enable,
  input wire logic        o_latch_strobe,
  input wire logic [15:0] o_latch_addr,
  input wire logic [7:0]  o_latch_data
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic req;  // Any bus request
  assign req = i_avs_read | i_avs_write;
  // One wait cycle, then the answer
  property p_wait; $rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing wrong");
  // Selects can never both stand
  property p_lock; !(o_program_select && o_erase_select); endproperty
  a_lock: assert property (p_lock) else $error("both selects high");
  // Voltage comes on only under a select
  property p_hv_sel; $rose(o_high_voltage_enable) |-> o_program_select || o_erase_select; endproperty
  a_hv_sel: assert property (p_hv_sel) else $error("voltage without select");
  // Voltage only after a control write asking for it
  property p_hv_cause;
    $rose(o_high_voltage_enable) |->
      $past(i_avs_write && i_avs_address == 4'h0 && i_avs_writedata[3]);
  endproperty
  a_hv_cause: assert property (p_hv_cause) else $error("voltage without request");
  // A taken write of zero drops the voltage
  property p_hv_drop;
    i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0 && !i_avs_writedata[3]
      |=> !o_high_voltage_enable;
  endproperty
  a_hv_drop: assert property (p_hv_drop) else $error("voltage stayed on");
  // Program select follows its control write
  property p_sel_cause;
    $rose(o_program_select) |-> $past(i_avs_write && i_avs_address == 4'h0 && i_avs_writedata[0]);
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("select without request");
  // Strobe is a single pulse
  property p_strobe; o_latch_strobe |=> !o_latch_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
  // Latched address and data are the ones written
  property p_latch;
    $rose(o_latch_strobe) |-> o_latch_addr == $past(i_avs_writedata[23:8])
      && o_latch_data == $past(i_avs_writedata[7:0]);
  endproperty
  a_latch: assert property (p_latch) else $error("latched value wrong");
  // Reset leaves program select, erase select, voltage and strobe off
  property p_reset;
    @(posedge i_sys_clk) disable iff (1'b0)
      i_reset |=> !(o_program_select | o_erase_select | o_high_voltage_enable | o_latch_strobe);
  endproperty
  a_reset: assert property (p_reset) else $error("control on after reset");
  c_hv: cover property ($rose(o_high_voltage_enable));
  c_strobe: cover property (o_latch_strobe);
  c_wait: cover property (req && o_avs_waitrequest ##1 !o_avs_waitrequest);
endmodule // frpp_checker
bind frpp_sequencer frpp_checker u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_program_select(o_program_select), .o_erase_select(o_erase_select),
  .o_high_voltage_enable(o_high_voltage_enable), .o_latch_strobe(o_latch_strobe),
  .o_latch_addr(o_latch_addr), .o_latch_data(o_latch_data));
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the row program sequencer
// Assumes: Short setup wait so the run stays brief
// Notes:   Protect byte is loaded at each reset
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        i_sys_clk, i_reset, i_avs_read, i_avs_write, i_test_high_voltage;
  logic [3:0]  i_avs_address;
  logic [31:0] i_avs_writedata, rd;
  logic [7:0]  i_protect_load;
  wire  [31:0] o_avs_readdata;
  wire         o_avs_waitrequest, o_program_select, o_erase_select, o_mass_select;
  wire         o_high_voltage_enable, o_latch_strobe;
  wire  [15:0] o_latch_addr;
  wire  [7:0]  o_latch_data;
  integer      err_total = 0, comparisons = 0, cycles = 0, strobes = 0;
  frpp_sequencer #(.SETUP_CYC(4)) uut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_test_high_voltage(i_test_high_voltage),
    .i_protect_load(i_protect_load), .o_program_select(o_program_select),
    .o_erase_select(o_erase_select), .o_mass_select(o_mass_select),
    .o_high_voltage_enable(o_high_voltage_enable), .o_latch_strobe(o_latch_strobe),
    .o_latch_addr(o_latch_addr), .o_latch_data(o_latch_data));
  initial begin
    i_sys_clk = 0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  // Count strobes and cut a hang short
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (o_latch_strobe === 1'b1) strobes <= strobes + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      close_out;
    end
  end
  task close_out;
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons = comparisons + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task rst(input logic [7:0] p, input logic tv);
    i_reset <= 1'b1;
    i_protect_load <= p;
    i_test_high_voltage <= tv;
    repeat (6) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
  endtask
  // Reset state, read-only protect, unmapped read, interlock, missing protect read
  task basics;
    rst(8'h5A, 1'b0);
    chk("reset", {o_program_select, o_erase_select, o_high_voltage_enable}, 0);
    bus(1, 4'h4, 32'h0);
    bus(0, 4'h4, 32'h0);
    chk("protect_ro", rd, 32'h5A);
    bus(0, 4'h2, 32'h0);
    chk("unmapped", rd, 0);
    bus(1, 4'h0, 32'h3);
    @(posedge i_sys_clk);
    chk("both_sel", {o_program_select, o_erase_select}, 0);
    bus(1, 4'h0, 32'h1);
    bus(1, 4'h0, 32'h3);
    @(posedge i_sys_clk);
    chk("erase_lock", {o_program_select, o_erase_select}, 2'b10);
    bus(1, 4'h0, 32'h9);
    @(posedge i_sys_clk);
    chk("no_prot_read", o_high_voltage_enable, 0);
  endtask
  // Full sequence with a given protect byte, select and target row
  task seq(input logic [7:0] p, input logic [3:0] sel, input logic [15:0] a,
           input logic tv, input logic g);
    integer i, n;
    rst(p, tv);
    bus(1, 4'h0, {28'h0, sel});
    chk("mass", o_mass_select, sel[2]);
    bus(0, 4'h4, 32'h0);
    chk("protect", rd, {24'h0, p});
    bus(1, 4'hC, {8'h80, a, 8'hA5});
    i = 0;
    rd = 0;
    // Always let the setup wait run out, so a refusal comes from protection or a missing test voltage
    while (rd[3] !== 1'b1 && i < 50) begin
      bus(0, 4'h8, 32'h0);
      i = i + 1;
    end
    chk("steps", rd[4:0], 5'h1B);
    bus(1, 4'h0, {28'h0, sel | 4'h8});
    @(posedge i_sys_clk);
    chk("high_voltage_enable", o_high_voltage_enable, g);
    bus(0, 4'h8, 32'h0);
    chk("refused", rd[2], !g);
    if (g && sel == 4'h1) begin
      n = strobes;
      bus(1, 4'hC, {8'h80, a, 8'h3C});
      bus(1, 4'hC, {8'h80, a + 16'h1, 8'hC3});
      bus(1, 4'hC, {8'h80, a + 16'h20, 8'h00});
      repeat (2) @(posedge i_sys_clk);
      chk("strobes", strobes - n, 2);
      chk("latch", {o_latch_addr, o_latch_data}, {a + 16'h1, 8'hC3});
      bus(1, 4'h0, 32'h8);
      @(posedge i_sys_clk);
      chk("pgm_off", {o_program_select, o_high_voltage_enable}, 2'b01);
    end
    bus(1, 4'h0, 32'h0);
    @(posedge i_sys_clk);
    chk("idle", o_high_voltage_enable, 0);
  endtask
  initial begin
    i_reset = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 4'h0;
    i_avs_writedata = 32'h0;
    i_protect_load = 8'hFF;
    i_test_high_voltage = 1'b0;
    basics;
    seq(8'hFF, 4'h1, 16'hC000, 1'b0, 1'b1);
    seq(8'h00, 4'h1, 16'hC000, 1'b0, 1'b0);
    seq(8'h01, 4'h1, 16'hC020, 1'b0, 1'b1);
    seq(8'h01, 4'h1, 16'hC040, 1'b0, 1'b0);
    seq(8'h01, 4'h1, 16'hBE00, 1'b0, 1'b0);
    seq(8'hFE, 4'h1, 16'hFF80, 1'b0, 1'b0);
    seq(8'hFF, 4'h1, 16'hFFBE, 1'b0, 1'b0);
    seq(8'hFF, 4'h1, 16'hFFBE, 1'b1, 1'b1);
    seq(8'hFF, 4'h6, 16'hC000, 1'b0, 1'b1);
    seq(8'h7F, 4'h6, 16'hC000, 1'b0, 1'b0);
    seq(8'hFF, 4'h2, 16'hC040, 1'b0, 1'b1);
    close_out;
  end
endmodule // tb
`default_nettype wire
